// ### strap_device.sv
// Converter end: reset classification, strap latch and pin roles
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module strap_device #(
    parameter int SEQ_LEN = 8,
    parameter int FS_UV_R1 = 2500000,
    parameter int FS_UV_R2 = 5000000,
    parameter int FS_UV_R3 = 10000000
) (
    input wire logic clk,
    input wire logic sys_rst,
    strap_link_if.device link,
    input wire logic signed [31:0] analog_uv,
    output logic internal_ref_en,
    output logic bandgap_powered_down,
    output logic ref_buffer_en,
    output logic software_mode,
    output logic [1:0] input_range,
    output logic sequencer_en,
    output logic [2:0] seq_channel,
    output logic parallel_mode,
    output logic byte_mode,
    output logic serial_mode,
    output logic two_lanes,
    output logic checksum_en,
    output logic nibble_bidir,
    output logic nibble_out_only,
    output logic signed [15:0] result,
    output logic result_valid,
    output logic full_reset_seen,
    output logic partial_reset_seen
);
    if (SEQ_LEN < 1 || SEQ_LEN > 8 || FS_UV_R1 < 1 || FS_UV_R2 < 1 || FS_UV_R3 < 1)
    begin : g_bad_params
        $error("SEQ_LEN must be 1 to 8 and full scales positive");
    end

    // Two-flop synchronisers for every pin the device samples
    logic [23:0] pin_s1_r, pin_s2_r;
    wire [23:0] pins = {link.db, link.range_and_mode_strap, link.interface_family_strap,
        link.sequencer_enable_strap, link.reference_source_strap, link.reset_n,
        link.conversion_trigger, link.read_n};
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Idle levels: read and reset high, trigger low, so no false edge follows
            pin_s1_r <= 24'h000005;
            pin_s2_r <= 24'h000005;
        end else begin
            pin_s1_r <= pins;
            pin_s2_r <= pin_s1_r;
        end
    end
    wire read_n_s = pin_s2_r[0];
    wire trig_s = pin_s2_r[1];
    wire rst_n_s = pin_s2_r[2];
    wire ref_s = pin_s2_r[3];
    wire seq_s = pin_s2_r[4];
    wire fam_s = pin_s2_r[5];
    wire [1:0] rng_s = pin_s2_r[7:6];
    wire [15:0] db_s = pin_s2_r[23:8];

    logic rst_n_d_r, trig_d_r, read_n_d_r;
    logic [15:0] low_cnt_r;
    logic [15:0] low_cnt_nxt;
    logic [15:0] db_hold_r;
    wire rst_rise = rst_n_s & ~rst_n_d_r;
    wire read_rise = read_n_s & ~read_n_d_r;
    wire trig_rise = trig_s & ~trig_d_r;
    wire read_fall = ~read_n_s & read_n_d_r;
    wire in_reset = ~rst_n_s;
    wire is_full = rst_rise && low_cnt_r >= 16'(strap_pkg::FULL_CYC);
    wire is_partial = rst_rise && !is_full && low_cnt_r >= 16'(strap_pkg::PARTIAL_CYC);
    assign low_cnt_nxt = in_reset ? (&low_cnt_r ? low_cnt_r : low_cnt_r + 16'h1) : 16'h0;

    // Latched configuration
    logic ref_r, seq_r, fam_r, bsel_r, lane_r, chk_r;
    logic [1:0] rng_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_n_d_r <= 1'b1;
            trig_d_r <= 1'b0;
            read_n_d_r <= 1'b1;
            low_cnt_r <= 16'h0;
            db_hold_r <= 16'h0;
        end else begin
            rst_n_d_r <= rst_n_s;
            trig_d_r <= trig_s;
            read_n_d_r <= read_n_s;
            low_cnt_r <= low_cnt_nxt;
            // Shared-pin straps are released together with reset, so keep the last low sample
            if (in_reset) db_hold_r <= db_s;
        end
    end

    // Only a full reset re-samples; partial and short pulses leave these alone
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_r <= 1'b1;
            seq_r <= 1'b0;
            fam_r <= 1'b0;
            bsel_r <= 1'b0;
            lane_r <= 1'b0;
            chk_r <= 1'b0;
            rng_r <= strap_pkg::RANGE_SW;
        end else if (is_full) begin
            ref_r <= ref_s;
            seq_r <= seq_s;
            rng_r <= rng_s;
            fam_r <= fam_s;
            bsel_r <= db_hold_r[strap_pkg::BYTE_OR_SERIAL_STRAP_BIT];
            lane_r <= db_hold_r[strap_pkg::LANE_BIT];
            chk_r <= db_hold_r[strap_pkg::CHK_BIT];
        end
    end

    assign internal_ref_en = ref_r;
    assign bandgap_powered_down = ~ref_r;
    assign ref_buffer_en = 1'b1;
    assign software_mode = (rng_r == strap_pkg::RANGE_SW);
    assign input_range = rng_r;
    assign sequencer_en = seq_r & ~software_mode;
    assign parallel_mode = ~fam_r;
    assign byte_mode = fam_r & bsel_r;
    assign serial_mode = fam_r & ~bsel_r;
    assign two_lanes = serial_mode & lane_r;
    assign checksum_en = serial_mode & chk_r;
    assign nibble_bidir = software_mode & ~serial_mode;
    assign nibble_out_only = ~software_mode & ~serial_mode;

    // Ideal quantiser: round(v * steps / span), clamped to the code range
    function automatic logic signed [15:0] quantise(input logic signed [31:0] uv,
        input logic [1:0] rng);
        logic signed [63:0] span;
        logic signed [63:0] q;
        span = 64'(2 * (rng == 2'h1 ? FS_UV_R1 : (rng == 2'h2 ? FS_UV_R2 : FS_UV_R3)));
        q = 64'(uv) * strap_pkg::CODE_STEPS;
        q = (q >= 0) ? (q + span / 2) / span : -((-q + span / 2) / span);
        if (q > 64'sd32767) q = 64'sd32767;
        if (q < -64'sd32768) q = -64'sd32768;
        quantise = 16'(q);
    endfunction

    // Conversion, sequencer and read logic; sys_rst clears all of it, reset_n low clears all but result, which clears only while read is low
    logic [15:0] conv_cnt_r;
    logic busy_r, byte_hi_r;
    logic [31:0] shift_r;
    logic [2:0] chan_r;
    wire conv_done = busy_r && conv_cnt_r == 16'h1;
    wire reading = ~read_n_s;
    wire [15:0] checksum = ~result;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_cnt_r <= 16'h0;
            busy_r <= 1'b0;
            result <= 16'sh0;
            result_valid <= 1'b0;
            chan_r <= 3'h0;
            byte_hi_r <= 1'b1;
            shift_r <= 32'h0;
        end else if (in_reset) begin
            busy_r <= 1'b0;
            result_valid <= 1'b0;
            conv_cnt_r <= 16'h0;
            chan_r <= 3'h0;
            byte_hi_r <= 1'b1;
            shift_r <= 32'h0;
            if (reading) result <= 16'sh0;
        end else begin
            if (trig_rise && !busy_r) begin
                busy_r <= 1'b1;
                conv_cnt_r <= 16'(strap_pkg::CONV_CYC);
                if (sequencer_en)
                    chan_r <= (chan_r == 3'(SEQ_LEN - 1)) ? 3'h0 : chan_r + 3'h1;
            end else if (busy_r) begin
                conv_cnt_r <= conv_cnt_r - 16'h1;
            end
            if (conv_done) begin
                busy_r <= 1'b0;
                result <= quantise(analog_uv, rng_r);
                result_valid <= 1'b1;
            end
            if (read_fall) begin
                shift_r <= {result, checksum};
            end else if (reading) begin
                shift_r <= {shift_r[30:0], 1'b0};
            end
            // Flip after the read, so the first read of a pair gives the high byte
            if (read_rise) byte_hi_r <= ~byte_hi_r;
        end
    end
    assign seq_channel = chan_r;

    // Data pins driven only during a read, and never in serial mode
    wire [15:0] par_oe = (reading && parallel_mode) ? 16'hFFFF : 16'h0;
    wire [15:0] byte_oe = (reading && byte_mode) ? 16'h00FF : 16'h0;
    wire [7:0] byte_val = byte_hi_r ? result[15:8] : result[7:0];
    assign link.db_dev_oe = par_oe | byte_oe;
    assign link.db_dev_o = byte_mode ? {8'h0, byte_val} : result;
    assign link.serial_out_lane_a = serial_mode & shift_r[31];
    assign link.serial_out_lane_b = two_lanes & shift_r[31];
    assign link.busy = busy_r;

    // Pulses that report the classified reset kind
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            full_reset_seen <= 1'b0;
            partial_reset_seen <= 1'b0;
        end else begin
            full_reset_seen <= is_full;
            partial_reset_seen <= is_partial;
        end
    end
endmodule // strap_device

// ### strap_pkg.sv
// Shared constants for the reset and strap latch link
package strap_pkg;
    localparam int CLK_NS = 8;
    localparam int PARTIAL_MIN_NS = 40;
    localparam int FULL_MIN_NS = 1200;
    localparam int TRIG_DELAY_NS = 200;
    localparam int CONV_NS = 480;
    localparam int PARTIAL_CYC = (PARTIAL_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int FULL_CYC = (FULL_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRIG_DELAY_CYC = (TRIG_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int CODE_STEPS = 65536;
    localparam int READ_CYC = 40;
    localparam int SERIAL_LAT_CYC = 5;
    localparam int LANE_BIT = 4;
    localparam int CHK_BIT = 5;
    localparam int BYTE_OR_SERIAL_STRAP_BIT = 9;
    localparam logic [1:0] RANGE_SW = 2'h0;
    // Host register map, one word each
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STRAPS = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_DATA = 4'hC;
    localparam int CMD_FULL = 0;
    localparam int CMD_PARTIAL = 1;
    localparam int CMD_CONV = 2;
    localparam int CMD_READ = 3;
    localparam logic [7:0] STRAPS_RST = 8'h03;
    typedef enum logic [1:0] {
        RST_NONE = 2'h0,
        RST_PARTIAL = 2'h1,
        RST_FULL = 2'h2
    } reset_kind_t;
endpackage

// ### strap_link_if.sv
// Pin-level link between host controller and converter
`timescale 1ns/1ps
interface strap_link_if;
    logic reset_n;
    logic conversion_trigger;
    logic read_n;
    logic reference_source_strap;
    logic sequencer_enable_strap;
    logic [1:0] range_and_mode_strap;
    logic interface_family_strap;
    logic [15:0] db_dev_o;
    logic [15:0] db_dev_oe;
    logic [15:0] db_host_o;
    logic [15:0] db_host_oe;
    logic [15:0] db;
    logic serial_out_lane_a;
    logic serial_out_lane_b;
    logic busy;
    // Undriven bits resolve low as if pulled to ground
    assign db = (db_dev_o & db_dev_oe) | (db_host_o & db_host_oe & ~db_dev_oe);
    modport device (input reset_n, conversion_trigger, read_n, reference_source_strap,
        sequencer_enable_strap, range_and_mode_strap, interface_family_strap, db,
        output db_dev_o, db_dev_oe, serial_out_lane_a, serial_out_lane_b, busy);
    modport host (output reset_n, conversion_trigger, read_n, reference_source_strap,
        sequencer_enable_strap, range_and_mode_strap, interface_family_strap,
        db_host_o, db_host_oe, input db, serial_out_lane_a, serial_out_lane_b, busy);
endinterface

// ### strap_host.sv
// Host end: AXI4-Lite command registers driving reset, straps and reads
`timescale 1ns/1ps
module strap_host (
    input wire logic clk,
    input wire logic sys_rst,
    strap_link_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_RST = 3'h1,
        H_WAIT = 3'h2,
        H_TRIG = 3'h3,
        H_READ = 3'h4
    } host_state_t;
    host_state_t st_r;
    logic [7:0] straps_r;
    logic [15:0] cnt_r, data_r;
    logic [17:0] in_s1_r, in_s2_r;
    logic aw_r, w_r, wstrb0_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_s1_r <= 18'h0;
            in_s2_r <= 18'h0;
        end else begin
            in_s1_r <= {link.busy, link.serial_out_lane_a, link.db};
            in_s2_r <= in_s1_r;
        end
    end
    wire serial = straps_r[4] & ~straps_r[5];
    wire do_write = aw_r && w_r && !s_axi_bvalid;
    wire cmd_hit = do_write && awaddr_r == strap_pkg::REG_CMD && st_r == H_IDLE;
    wire [15:0] rst_len = wdata_r[strap_pkg::CMD_FULL] ?
        16'(strap_pkg::FULL_CYC + 2) : 16'(strap_pkg::PARTIAL_CYC + 2);
    wire ser_take = cnt_r >= 16'(strap_pkg::SERIAL_LAT_CYC) &&
        cnt_r < 16'(strap_pkg::SERIAL_LAT_CYC + 16);
    assign s_axi_awready = !aw_r;
    assign s_axi_wready = !w_r;
    assign s_axi_bresp = 2'h0;
    assign s_axi_rresp = 2'h0;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h0;
            wstrb0_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            straps_r <= strap_pkg::STRAPS_RST;
        end else begin
            if (s_axi_awvalid && !aw_r) begin
                aw_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_r) begin
                w_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_r <= 1'b0;
                w_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_r == strap_pkg::REG_STRAPS && wstrb0_r)
                    straps_r <= wdata_r[7:0];
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                case (s_axi_araddr)
                    strap_pkg::REG_STRAPS: s_axi_rdata <= {24'h0, straps_r};
                    strap_pkg::REG_STATUS: s_axi_rdata <= {30'h0, in_s2_r[17], st_r != H_IDLE};
                    strap_pkg::REG_DATA: s_axi_rdata <= {16'h0, data_r};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // Sequencer of pin activity; one command at a time, others ignored while busy
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= H_IDLE;
            cnt_r <= 16'h0;
            data_r <= 16'h0;
        end else begin
            case (st_r)
                H_IDLE: begin
                    cnt_r <= 16'h0;
                    if (cmd_hit && |wdata_r[1:0]) begin
                        st_r <= H_RST;
                        cnt_r <= rst_len;
                    end else if (cmd_hit && wdata_r[strap_pkg::CMD_CONV]) begin
                        st_r <= H_TRIG;
                        cnt_r <= 16'h4;
                    end else if (cmd_hit && wdata_r[strap_pkg::CMD_READ]) begin
                        st_r <= H_READ;
                    end
                end
                H_RST: begin
                    cnt_r <= cnt_r - 16'h1;
                    if (cnt_r == 16'h1) begin
                        st_r <= H_WAIT;
                        cnt_r <= 16'(strap_pkg::TRIG_DELAY_CYC + 4);
                    end
                end
                H_WAIT: begin
                    cnt_r <= cnt_r - 16'h1;
                    if (cnt_r == 16'h1) st_r <= H_IDLE;
                end
                H_TRIG: begin
                    cnt_r <= cnt_r - 16'h1;
                    if (cnt_r == 16'h1) st_r <= H_IDLE;
                end
                H_READ: begin
                    cnt_r <= cnt_r + 16'h1;
                    if (serial && ser_take) data_r <= {data_r[14:0], in_s2_r[16]};
                    if (cnt_r == 16'(strap_pkg::READ_CYC - 1)) begin
                        st_r <= H_IDLE;
                        if (!serial) data_r <= straps_r[5] && straps_r[4] ?
                            {data_r[7:0], in_s2_r[7:0]} : in_s2_r[15:0];
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end
    assign link.reset_n = (st_r != H_RST);
    assign link.conversion_trigger = (st_r == H_TRIG);
    assign link.read_n = (st_r != H_READ);
    assign link.reference_source_strap = straps_r[0];
    assign link.sequencer_enable_strap = straps_r[1];
    assign link.range_and_mode_strap = straps_r[3:2];
    assign link.interface_family_strap = straps_r[4];
    // Multiplexed straps driven only while reset is low; serial grounds the low nibble
    wire [15:0] strap_bits = 16'(straps_r[5]) << strap_pkg::BYTE_OR_SERIAL_STRAP_BIT |
        16'(straps_r[6]) << strap_pkg::LANE_BIT | 16'(straps_r[7]) << strap_pkg::CHK_BIT;
    assign link.db_host_o = (st_r == H_RST) ? strap_bits : 16'h0;
    assign link.db_host_oe = (st_r == H_RST) ? 16'hFFFF : (serial ? 16'h000F : 16'h0);
endmodule // strap_host

// ### strap_link_checker.sv
// Assertions on the host-to-converter link pins
`timescale 1ns/1ps
module strap_link_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic conversion_trigger,
    input wire logic read_n,
    input wire logic [1:0] range_and_mode_strap,
    input wire logic interface_family_strap,
    input wire logic [15:0] db,
    input wire logic [15:0] db_dev_oe,
    input wire logic serial_out_lane_b,
    input wire logic busy
);
    logic rn_r;
    logic [7:0] low_r;
    logic [7:0] since_r;
    logic [4:0] pend_r;
    logic [4:0] mode_r;
    // Mode mirror: {range, family, byte select, lane count}
    wire full_rel = reset_n && !rn_r && (int'(low_r) >= strap_pkg::FULL_CYC);
    wire hw_mode = mode_r[4:3] != strap_pkg::RANGE_SW;
    wire ser_mode = mode_r[2] && !mode_r[1];
    wire low_inc = low_r != 8'hFF;
    wire since_inc = since_r != 8'hFF;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rn_r <= 1'b1;
            low_r <= 8'h00;
            since_r <= 8'hFF;
            pend_r <= 5'h00;
            mode_r <= 5'h00;
        end else begin
            rn_r <= reset_n;
            low_r <= reset_n ? 8'h00 : low_r + {7'h00, low_inc};
            since_r <= !reset_n ? 8'h00 : since_r + {7'h00, since_inc};
            // Sampled while low so a strap released at the rising edge is still seen
            if (!reset_n) pend_r <= {range_and_mode_strap, interface_family_strap,
                db[strap_pkg::BYTE_OR_SERIAL_STRAP_BIT], db[strap_pkg::LANE_BIT]};
            if (full_rel) mode_r <= pend_r;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_part_min;
        $fell(reset_n) |-> !reset_n [*5];
    endproperty
    a_part_min: assert property (p_part_min) else $error("reset pulse too short");
    property p_trig_gap;
        $rose(conversion_trigger) |-> int'(since_r) >= strap_pkg::TRIG_DELAY_CYC;
    endproperty
    a_trig_gap: assert property (p_trig_gap) else $error("trigger too soon after reset");
    property p_abort;
        $fell(reset_n) |-> ##[0:6] !busy;
    endproperty
    a_abort: assert property (p_abort) else $error("conversion not aborted");
    property p_conv_start;
        $rose(conversion_trigger) && !busy && reset_n |-> ##[1:6] busy;
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("trigger did not start");
    property p_par_drive;
        !mode_r[2] && read_n && $past(read_n, 2) |-> db_dev_oe == 16'h0000;
    endproperty
    a_par_drive: assert property (p_par_drive) else $error("bus driven outside read");
    property p_hw_drive;
        hw_mode && read_n && $past(read_n, 2) |-> db_dev_oe[3:0] == 4'h0;
    endproperty
    a_hw_drive: assert property (p_hw_drive) else $error("nibble driven outside read");
    property p_ser_nibble;
        ser_mode |-> db_dev_oe[3:0] == 4'h0;
    endproperty
    a_ser_nibble: assert property (p_ser_nibble) else $error("nibble driven in serial");
    property p_one_lane;
        ser_mode && !mode_r[0] |-> $stable(serial_out_lane_b);
    endproperty
    a_one_lane: assert property (p_one_lane) else $error("lane b active on one lane");
    c_full: cover property (full_rel);
    c_trig: cover property ($rose(conversion_trigger));
    c_ser_read: cover property (ser_mode && !read_n);
endmodule // strap_link_checker

// ### test_reset_mode_strap_latch.sv
// Self-checking bench for the reset and strap latch link
`timescale 1ns/1ps
`define CHECK(act, exp) begin check_count++; if ((act) !== (exp)) begin num_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, act, exp); end end
module test_reset_mode_strap_latch;
    typedef struct {
        logic [7:0] straps;
        logic [31:0] uv;
        logic [15:0] code;
        logic [13:0] outs;
    } row_t;
    row_t rows [6];
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [3:0] araddr = 4'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic signed [31:0] analog_uv = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, result_valid, full_seen, part_seen;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] seq_channel;
    logic signed [15:0] result;
    wire [13:0] outs;
    int num_errors = 0;
    int check_count = 0;
    int n_full = 0;
    int n_part = 0;
    logic [31:0] d;
    int nf;
    int np;
    int polls;

    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (full_seen === 1'b1) n_full++;
        if (part_seen === 1'b1) n_part++;
    end

    strap_link_if link ();
    strap_device i_strap_device (.clk(clk), .sys_rst(sys_rst), .link(link.device),
        .analog_uv(analog_uv), .internal_ref_en(outs[13]), .bandgap_powered_down(outs[12]),
        .ref_buffer_en(outs[11]), .software_mode(outs[10]), .input_range(outs[9:8]),
        .sequencer_en(outs[7]), .seq_channel(seq_channel), .parallel_mode(outs[6]),
        .byte_mode(outs[5]), .serial_mode(outs[4]), .two_lanes(outs[3]),
        .checksum_en(outs[2]), .nibble_bidir(outs[1]), .nibble_out_only(outs[0]),
        .result(result), .result_valid(result_valid), .full_reset_seen(full_seen),
        .partial_reset_seen(part_seen));
    strap_host i_strap_host (.clk(clk), .sys_rst(sys_rst), .link(link.host),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    strap_link_checker i_strap_link_checker (.clk(clk), .sys_rst(sys_rst),
        .reset_n(link.reset_n), .conversion_trigger(link.conversion_trigger),
        .read_n(link.read_n), .range_and_mode_strap(link.range_and_mode_strap),
        .interface_family_strap(link.interface_family_strap), .db(link.db),
        .db_dev_oe(link.db_dev_oe), .serial_out_lane_b(link.serial_out_lane_b),
        .busy(link.busy));

    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic bound(input int n);
        if (n >= 1000) begin
            num_errors++;
            $display("[FAIL] %0t wait timed out", $time);
            results();
        end
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 1000);
        bready <= 1'b0;
        bound(n);
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 1000);
        v = rdata;
        rready <= 1'b0;
        bound(n);
    endtask

    // Engine and converter both idle; a command issued while the engine is busy would be dropped
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            axi_read(strap_pkg::REG_STATUS, s);
            n++;
        end while (s[1:0] !== 2'h0 && n < 1000);
        bound(n);
    endtask

    task automatic run_row(input row_t r);
        logic [31:0] v;
        logic [2:0] ch;
        int f;
        f = n_full;
        axi_write(strap_pkg::REG_STRAPS, {24'h0, r.straps});
        axi_write(strap_pkg::REG_CMD, 32'h1);
        wait_idle();
        `CHECK(outs, r.outs)
        `CHECK(n_full, f + 1)
        ch = seq_channel;
        analog_uv <= r.uv;
        axi_write(strap_pkg::REG_CMD, 32'h4);
        wait_idle();
        `CHECK(result, r.code)
        `CHECK(result_valid, 1'b1)
        if (r.outs[7]) `CHECK(seq_channel, ch + 3'h1)
        // Byte mode needs two reads, high byte first
        repeat (r.outs[5] ? 2 : 1) begin
            axi_write(strap_pkg::REG_CMD, 32'h8);
            wait_idle();
        end
        axi_read(strap_pkg::REG_DATA, v);
        `CHECK(v[15:0], r.code)
        $display("mode row %h done", r.straps);
    endtask

    initial begin
        rows[0] = '{8'h03, 32'h000F4240, 16'h0CCD, 14'h2C42};
        rows[1] = '{8'h06, 32'hFFF0BDC0, 16'hCCCD, 14'h19C1};
        rows[2] = '{8'h38, 32'h001E8480, 16'h3333, 14'h1A21};
        rows[3] = '{8'h31, 32'hFFD23940, 16'hD99A, 14'h2C22};
        rows[4] = '{8'h5D, 32'h003D0900, 16'h3333, 14'h2B18};
        rows[5] = '{8'h90, 32'h00000099, 16'h0001, 14'h1C14};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHECK(outs, 14'h2C42)
        `CHECK(result_valid, 1'b0)
        axi_read(strap_pkg::REG_STRAPS, d);
        `CHECK(d[7:0], strap_pkg::STRAPS_RST)
        $display("reset defaults done");
        foreach (rows[i]) run_row(rows[i]);
        // Straps move while latched, then a partial reset must keep the old mode
        nf = n_full;
        np = n_part;
        axi_write(strap_pkg::REG_STRAPS, 32'h07);
        axi_read(strap_pkg::REG_STRAPS, d);
        `CHECK(d[7:0], 8'h07)
        `CHECK(outs, 14'h1C14)
        axi_write(strap_pkg::REG_CMD, 32'h2);
        wait_idle();
        `CHECK(outs, 14'h1C14)
        `CHECK(n_part, np + 1)
        `CHECK(n_full, nf)
        $display("partial reset done");
        // Reset lands while the converter is busy; the result must be marked invalid
        axi_write(strap_pkg::REG_CMD, 32'h4);
        polls = 0;
        do begin
            axi_read(strap_pkg::REG_STATUS, d);
            polls++;
        end while (d[1:0] !== 2'h2 && polls < 1000);
        bound(polls);
        axi_write(strap_pkg::REG_CMD, 32'h2);
        wait_idle();
        `CHECK(result_valid, 1'b0)
        `CHECK(outs, 14'h1C14)
        $display("abort done");
        results();
    end
endmodule // test_reset_mode_strap_latch
